// ==== core/ads_cfg.svh ====
// constants for the acquisition diagnostic selector
// assumes a 20 MHz clock and a scan sequencer outside this block
`ifndef ADS_CFG_SVH
`define ADS_CFG_SVH
// diagnostic slot selection codes
`define ADS_SEL_NONE 4'h0
`define ADS_SEL_COMP_PATH 4'h4
`define ADS_SEL_GAIN_CAL 4'h5
`define ADS_SEL_OFFSET_CAL 4'h6
`define ADS_SEL_THERMISTOR_REFERENCE_OFS 4'h9
`define ADS_SEL_ZERO_SCALE 4'hA
`define ADS_SEL_FULL_SCALE 4'hB
`define ADS_SEL_LSAMP_OFS 4'hC
// scan types that use the comparator
`define ADS_SCAN_COMP_A 3'h1
`define ADS_SCAN_COMP_B 3'h2
// threshold converter value for the comparator path diagnostic
`define ADS_DAC_QUARTER 12'h03FF
// result field position inside a slot result register
`define ADS_RES_LSB 2
`define ADS_RES_MSB 15
`define ADS_RES_RESET 16'h0000
`define ADS_FAULT_RESET 2'h0
`endif

// ==== core/ads_pkg.sv ====
// types for the acquisition diagnostic selector
// assumes ads_cfg.svh for numbers
package ads_pkg;
  // routing choices into the adc front end
  typedef enum logic [2:0] {
    ADS_SRC_CELL, ADS_SRC_PREAMP, ADS_SRC_REF_LS1, ADS_SRC_SHORT_ADC, ADS_SRC_GND_LS1,
    ADS_SRC_GND_THERMISTOR_REFERENCE, ADS_SRC_SHORT_LS, ADS_SRC_NEG_SUPPLY
  } ads_src_e;
  // analog front-end steering for one conversion
  typedef struct packed {
    ads_src_e src;               // input routing
    logic posSupply;             // full-scale source selected
    logic bipolar;               // forced bipolar polarity
    logic chop;                  // two chopped phases
    logic useThrmRef;            // thermistor reference as adc reference
    logic dacFromDiag;           // threshold converter driven by diagnostic
  } ads_route_s;
  // sequencer phase of this block
  typedef enum logic [2:0] {
    ADS_ST_IDLE, ADS_ST_SLOT1, ADS_ST_SLOT2, ADS_ST_ACC, ADS_ST_ZS, ADS_ST_FS, ADS_ST_DONE
  } ads_state_e;
endpackage

// ==== core/ads_route_dec.sv ====
// decoder from a slot selection code to front-end steering
// assumes the caller supplies the scan style of the current scan
`timescale 1ns/10ps
`include "ads_cfg.svh"
module ads_route_dec (
  input wire logic [3:0] selCode,
  input wire logic conversionSequenceStyle,
  output ads_pkg::ads_route_s route
);
  // pure decode, no state
  always_comb begin
    route = '{src: ads_pkg::ADS_SRC_CELL, posSupply: 1'b0, bipolar: 1'b0,
              chop: ~conversionSequenceStyle, useThrmRef: 1'b0, dacFromDiag: 1'b0};
    unique case (selCode)
      `ADS_SEL_COMP_PATH: begin
        route.src = ads_pkg::ADS_SRC_PREAMP;
        route.dacFromDiag = 1'b1;
      end
      `ADS_SEL_GAIN_CAL: begin
        route.src = ads_pkg::ADS_SRC_REF_LS1;
        route.chop = ~conversionSequenceStyle;
      end
      `ADS_SEL_OFFSET_CAL: begin
        route.bipolar = 1'b1;
        if (conversionSequenceStyle) begin
          route.src = ads_pkg::ADS_SRC_GND_LS1;
          route.chop = 1'b0;
        end else begin
          route.src = ads_pkg::ADS_SRC_SHORT_ADC;
        end
      end
      `ADS_SEL_THERMISTOR_REFERENCE_OFS: begin
        route.src = ads_pkg::ADS_SRC_GND_THERMISTOR_REFERENCE;
        route.useThrmRef = 1'b1;
        route.bipolar = 1'b1;
      end
      `ADS_SEL_LSAMP_OFS: begin
        route.src = ads_pkg::ADS_SRC_SHORT_LS;
        route.bipolar = 1'b1;
        route.chop = 1'b0; // offset must stay visible
      end
      `ADS_SEL_ZERO_SCALE: begin
        route.src = ads_pkg::ADS_SRC_NEG_SUPPLY;
        route.bipolar = 1'b1;
      end
      `ADS_SEL_FULL_SCALE: begin
        route.src = ads_pkg::ADS_SRC_NEG_SUPPLY;
        route.posSupply = 1'b1;
        route.bipolar = 1'b1;
      end
      default: begin
        // other codes leave the normal cell path in place
      end
    endcase
  end
endmodule

// ==== core/ads_diag_selector.sv ====
// acquisition diagnostic selector: end-of-scan diagnostic sequencing
// assumes an outside scan engine that converts on convStart and answers convDone
//
// How it works
// - diagnostic result lands in bits 15:2
// - code 0100 routes preamp, converter 03FFh
// - accuracy check only comparator scans, enabled
// - accuracy check: reference in, limits drive converter
// - over and under limit flags set
// - ideal comparator at 3FFh trips over only
// - accuracy check once after last oversample
// - gain check chops in pyramid only
// - offset check shorts per style, bipolar
// - thermistor offset grounded, bipolar
// - amplifier offset shorted, bipolar, unchopped
// - zero scale uses negative supply, bipolar
// - full scale uses positive supply, bipolar
// - stuck check appends zero/full pair
`timescale 1ns/10ps
`include "ads_cfg.svh"
module ads_diag_selector (
  input wire logic clk,
  input wire logic rst,
  input wire logic scanEnd,                 // pulse: last oversample finished
  input wire logic [2:0] scanTypeField,
  input wire logic conversionSequenceStyle, // 0 pyramid, 1 ramp
  input wire logic [3:0] diagSlotOneSelect,
  input wire logic [3:0] diagSlotTwoSelect,
  input wire logic compAccuracyCheckEnable,
  input wire logic endScanStuckCheckEnable,
  input wire logic [11:0] accuracyHighLimit,
  input wire logic [11:0] accuracyLowLimit,
  input wire logic convDone,                // pulse: conversion finished
  input wire logic [13:0] convResult,
  input wire logic compTrip,                // comparator output with convDone
  input wire logic faultClear,              // pulse: clear accuracy flags
  output logic convStart,
  output ads_pkg::ads_route_s route,
  output logic [11:0] thresholdDac,
  output logic ls2RefSelect,
  output logic [15:0] diagSlotOneResult,
  output logic [15:0] diagSlotTwoResult,
  output logic [1:0] faultStatusTwo,        // bit1 over, bit0 under
  output logic [13:0] stuckZeroResult,
  output logic [13:0] stuckFullResult,
  output logic seqBusy
);
  ads_pkg::ads_state_e state_reg, state_next;
  logic waiting_reg;          // conversion issued, result pending
  logic accHighPhase_reg;     // accuracy check phase: high then low
  ads_pkg::ads_route_s slotRoute; // decoded steering of the active slot
  logic [3:0] activeSel;      // slot code of the current phase
  logic accWanted;            // accuracy check allowed this scan
  logic [15:0] resWord;       // result placed in register field

  // placement of the 14-bit value
  function automatic logic [15:0] placeResult(input logic [13:0] r);
    placeResult = {r, 2'b00};
  endfunction

  // gate: only comparator scans with enable set
  assign accWanted = compAccuracyCheckEnable &&
                     (scanTypeField == `ADS_SCAN_COMP_A ||
                      scanTypeField == `ADS_SCAN_COMP_B);
  assign resWord = placeResult(convResult);

  // code feeding the shared decoder
  always_comb begin
    unique case (state_reg)
      ads_pkg::ADS_ST_SLOT1: activeSel = diagSlotOneSelect;
      ads_pkg::ADS_ST_SLOT2: activeSel = diagSlotTwoSelect;
      ads_pkg::ADS_ST_ZS: activeSel = `ADS_SEL_ZERO_SCALE;
      ads_pkg::ADS_ST_FS: activeSel = `ADS_SEL_FULL_SCALE;
      default: activeSel = `ADS_SEL_NONE;
    endcase
  end

  ads_route_dec uDec (
    .selCode(activeSel),
    .conversionSequenceStyle(conversionSequenceStyle),
    .route(slotRoute)
  );

  // front-end steering; idle and done phases fall back to cell path
  always_comb begin
    route = slotRoute;
    ls2RefSelect = (state_reg == ads_pkg::ADS_ST_ACC);
    if (state_reg == ads_pkg::ADS_ST_ACC) begin
      thresholdDac = accHighPhase_reg ? accuracyHighLimit : accuracyLowLimit;
    end else if (slotRoute.dacFromDiag) begin
      thresholdDac = `ADS_DAC_QUARTER;
    end else begin
      thresholdDac = accuracyHighLimit;
    end
  end

  // next phase after a finished step; skips unused steps
  function automatic ads_pkg::ads_state_e after(input ads_pkg::ads_state_e s,
                                                input logic acc, input logic stuck,
                                                input logic [3:0] s2);
    ads_pkg::ads_state_e n;
    n = s;
    if (s == ads_pkg::ADS_ST_SLOT1) begin
      n = (s2 != `ADS_SEL_NONE) ? ads_pkg::ADS_ST_SLOT2 : ads_pkg::ADS_ST_IDLE;
    end
    if (n == ads_pkg::ADS_ST_IDLE || s == ads_pkg::ADS_ST_SLOT2) begin
      n = acc ? ads_pkg::ADS_ST_ACC : (stuck ? ads_pkg::ADS_ST_ZS : ads_pkg::ADS_ST_DONE);
    end
    if (s == ads_pkg::ADS_ST_ACC) begin
      n = stuck ? ads_pkg::ADS_ST_ZS : ads_pkg::ADS_ST_DONE;
    end
    if (s == ads_pkg::ADS_ST_ZS) begin
      n = ads_pkg::ADS_ST_FS;
    end
    if (s == ads_pkg::ADS_ST_FS) begin
      n = ads_pkg::ADS_ST_DONE;
    end
    after = n;
  endfunction

  // phase sequencing; one pass per scan end
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ads_pkg::ADS_ST_IDLE: begin
        if (scanEnd) begin
          state_next = (diagSlotOneSelect != `ADS_SEL_NONE) ? ads_pkg::ADS_ST_SLOT1 :
                       after(ads_pkg::ADS_ST_SLOT1, accWanted, endScanStuckCheckEnable,
                             diagSlotTwoSelect);
        end
      end
      ads_pkg::ADS_ST_ACC: begin
        if (waiting_reg && convDone && !accHighPhase_reg) begin
          state_next = after(state_reg, accWanted, endScanStuckCheckEnable,
                             diagSlotTwoSelect);
        end
      end
      ads_pkg::ADS_ST_DONE: state_next = ads_pkg::ADS_ST_IDLE;
      default: begin
        if (waiting_reg && convDone) begin
          state_next = after(state_reg, accWanted, endScanStuckCheckEnable,
                             diagSlotTwoSelect);
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ads_pkg::ADS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // conversion handshake: one start per step, two in the accuracy check (high then low), wait for done
  always_ff @(posedge clk) begin
    if (rst) begin
      waiting_reg <= 1'b0;
    end else if (convStart) begin
      waiting_reg <= 1'b1;
    end else if (convDone) begin
      waiting_reg <= 1'b0;
    end
  end
  assign convStart = !waiting_reg && state_reg != ads_pkg::ADS_ST_IDLE &&
                     state_reg != ads_pkg::ADS_ST_DONE;
  assign seqBusy = (state_reg != ads_pkg::ADS_ST_IDLE);

  // accuracy check: high limit first, then low limit
  always_ff @(posedge clk) begin
    if (rst) begin
      accHighPhase_reg <= 1'b1;
    end else if (state_reg != ads_pkg::ADS_ST_ACC) begin
      accHighPhase_reg <= 1'b1;
    end else if (waiting_reg && convDone) begin
      accHighPhase_reg <= 1'b0;
    end
  end

  // slot result registers
  always_ff @(posedge clk) begin
    if (rst) begin
      diagSlotOneResult <= `ADS_RES_RESET;
      diagSlotTwoResult <= `ADS_RES_RESET;
    end else if (waiting_reg && convDone) begin
      if (state_reg == ads_pkg::ADS_ST_SLOT1) begin
        diagSlotOneResult <= resWord;
      end
      if (state_reg == ads_pkg::ADS_ST_SLOT2) begin
        diagSlotTwoResult <= resWord;
      end
    end
  end

  // stuck-bit pair results
  always_ff @(posedge clk) begin
    if (rst) begin
      stuckZeroResult <= '0;
      stuckFullResult <= '0;
    end else if (waiting_reg && convDone) begin
      if (state_reg == ads_pkg::ADS_ST_ZS) begin
        stuckZeroResult <= convResult;
      end
      if (state_reg == ads_pkg::ADS_ST_FS) begin
        stuckFullResult <= convResult;
      end
    end
  end

  // sticky accuracy flags; a trip in the clear cycle still sets
  // compTrip high means the reference exceeds the programmed limit
  always_ff @(posedge clk) begin
    if (rst) begin
      faultStatusTwo <= `ADS_FAULT_RESET;
    end else begin
      if (state_reg == ads_pkg::ADS_ST_ACC && waiting_reg && convDone) begin
        if (accHighPhase_reg) begin
          faultStatusTwo[1] <= compTrip || (faultStatusTwo[1] && !faultClear);
          faultStatusTwo[0] <= faultStatusTwo[0] && !faultClear;
        end else begin
          faultStatusTwo[0] <= !compTrip || (faultStatusTwo[0] && !faultClear);
          faultStatusTwo[1] <= faultStatusTwo[1] && !faultClear;
        end
      end else if (faultClear) begin
        faultStatusTwo <= `ADS_FAULT_RESET;
      end
    end
  end

  // checks
  property p_resPlace;
    @(posedge clk) disable iff (rst)
      (state_reg == ads_pkg::ADS_ST_SLOT1 && waiting_reg && convDone)
      |=> diagSlotOneResult == {$past(convResult), 2'b00};
  endproperty
  a_resPlace: assert property (p_resPlace) else $error("slot one result misplaced");
  property p_compDac;
    @(posedge clk) disable iff (rst)
      (route.src == ads_pkg::ADS_SRC_PREAMP) |-> thresholdDac == 12'h03FF;
  endproperty
  a_compDac: assert property (p_compDac) else $error("comparator path dac wrong");
  property p_accGate;
    @(posedge clk) disable iff (rst)
      (state_reg == ads_pkg::ADS_ST_ACC) |-> accWanted;
  endproperty
  a_accGate: assert property (p_accGate) else $error("accuracy check not allowed");
  property p_accRef;
    @(posedge clk) disable iff (rst)
      (state_reg == ads_pkg::ADS_ST_ACC && accHighPhase_reg)
      |-> ls2RefSelect && thresholdDac == accuracyHighLimit;
  endproperty
  a_accRef: assert property (p_accRef) else $error("accuracy steering wrong");
  property p_overSet;
    @(posedge clk) disable iff (rst)
      (state_reg == ads_pkg::ADS_ST_ACC && accHighPhase_reg && waiting_reg && convDone
       && compTrip) |=> faultStatusTwo[1];
  endproperty
  a_overSet: assert property (p_overSet) else $error("over limit flag missed");
  sequence s_zeroStep;
    state_reg == ads_pkg::ADS_ST_ZS && waiting_reg && convDone;
  endsequence
  property p_pair;
    @(posedge clk) disable iff (rst)
      s_zeroStep |=> state_reg == ads_pkg::ADS_ST_FS;
  endproperty
  a_pair: assert property (p_pair) else $error("full scale step missing");
  property p_once;
    @(posedge clk) disable iff (rst)
      (state_reg == ads_pkg::ADS_ST_ACC && !accHighPhase_reg && waiting_reg && convDone)
      |=> state_reg != ads_pkg::ADS_ST_ACC;
  endproperty
  a_once: assert property (p_once) else $error("accuracy check repeated");
  property p_restore;
    @(posedge clk) disable iff (rst)
      (state_reg == ads_pkg::ADS_ST_DONE) |=> (route.src == ads_pkg::ADS_SRC_CELL
      && !route.bipolar);
  endproperty
  a_restore: assert property (p_restore) else $error("routing not restored");
  property p_lsOfs;
    @(posedge clk) disable iff (rst)
      (route.src == ads_pkg::ADS_SRC_SHORT_LS) |-> route.bipolar && !route.chop;
  endproperty
  a_lsOfs: assert property (p_lsOfs) else $error("amplifier offset steering wrong");
endmodule

// ==== tb/ads_diag_selector_tb_top.sv ====
// self-checking bench for the acquisition diagnostic selector
// assumes the design files under core/ and a 20 MHz clock; the bench plays the converter
`timescale 1ns/10ps
module ads_diag_selector_tb_top;
  // one table row: slot code, style, expected steering, converter answer
  typedef struct packed {
    logic [3:0] code;
    logic style;
    ads_pkg::ads_src_e src;
    logic bip;
    logic bipCare;
    logic chop;
    logic chopCare;
    logic pos;
    logic thermistor_reference;
    logic [13:0] res;
  } ads_tbrow_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scanEnd = 1'b0;
  logic [2:0] scanTypeField = 3'h0;
  logic conversionSequenceStyle = 1'b0;
  logic [3:0] diagSlotOneSelect = 4'h0;
  logic [3:0] diagSlotTwoSelect = 4'h0;
  logic compAccuracyCheckEnable = 1'b0;
  logic endScanStuckCheckEnable = 1'b0;
  logic [11:0] accuracyHighLimit = 12'h03FF;
  logic [11:0] accuracyLowLimit = 12'h03FF;
  logic convDone = 1'b0;
  logic [13:0] convResult = 14'h0000;
  logic compTrip = 1'b0;
  logic faultClear = 1'b0;
  logic convStart;
  ads_pkg::ads_route_s route;
  logic [11:0] thresholdDac;
  logic ls2RefSelect;
  logic [15:0] diagSlotOneResult;
  logic [15:0] diagSlotTwoResult;
  logic [1:0] faultStatusTwo;
  logic [13:0] stuckZeroResult;
  logic [13:0] stuckFullResult;
  logic seqBusy;
  // steering seen when a conversion was issued
  ads_pkg::ads_route_s capRoute;
  logic [11:0] capDac;
  logic capLs2;
  int errTotal = 0;
  int checkCount = 0;
  int corr; // host limit correction in converter codes
  ads_tbrow_s rows [9];

  ads_diag_selector dut (.clk(clk), .rst(rst), .scanEnd(scanEnd), .scanTypeField(scanTypeField),
    .conversionSequenceStyle(conversionSequenceStyle), .diagSlotOneSelect(diagSlotOneSelect),
    .diagSlotTwoSelect(diagSlotTwoSelect), .compAccuracyCheckEnable(compAccuracyCheckEnable),
    .endScanStuckCheckEnable(endScanStuckCheckEnable), .accuracyHighLimit(accuracyHighLimit),
    .accuracyLowLimit(accuracyLowLimit), .convDone(convDone), .convResult(convResult),
    .compTrip(compTrip), .faultClear(faultClear), .convStart(convStart), .route(route),
    .thresholdDac(thresholdDac), .ls2RefSelect(ls2RefSelect),
    .diagSlotOneResult(diagSlotOneResult), .diagSlotTwoResult(diagSlotTwoResult),
    .faultStatusTwo(faultStatusTwo), .stuckZeroResult(stuckZeroResult),
    .stuckFullResult(stuckFullResult), .seqBusy(seqBusy));

  // 50 ns period
  always #25 clk = ~clk;

  // vector compare, narrower values zero-extended by the caller
  task chkVal(input string what, input logic [15:0] exp, input logic [15:0] got);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // routing choice compare
  task chkSrc(input ads_pkg::ads_src_e exp, input ads_pkg::ads_src_e got);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch route.src expected %0d seen %0d", exp, got);
    end
  endtask
  task stopTest;
    if (errTotal == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one-cycle scan-end pulse, returns at the edge that sampled it
  task pulseScan;
    @(posedge clk) scanEnd <= 1'b1;
    @(posedge clk) scanEnd <= 1'b0;
  endtask
  // serve one conversion; dup raises scanEnd again while the pass is busy
  task doConv(input logic [13:0] r, input logic t, input int slow, input logic dup);
    int n;
    n = 0;
    @(negedge clk);
    while (convStart !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      errTotal++;
      $display("mismatch convStart expected 1 seen 0");
      stopTest();
    end
    capRoute = route;
    capDac = thresholdDac;
    capLs2 = ls2RefSelect;
    @(posedge clk) scanEnd <= dup;
    repeat (slow) @(posedge clk);
    convDone <= 1'b1;
    convResult <= r;
    compTrip <= t;
    @(posedge clk) convDone <= 1'b0;
    scanEnd <= 1'b0; // one edge later, so no double drive when slow is 0
    convResult <= ~r; // stale data must not be trusted
  endtask
  // bounded wait for the pass to finish
  task waitIdle;
    int n;
    n = 0;
    @(negedge clk);
    while (seqBusy !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      errTotal++;
      $display("mismatch seqBusy expected 0 seen 1");
      stopTest();
    end
  endtask
  // no conversion may be issued for six cycles
  task noConv;
    repeat (6) begin
      @(negedge clk);
      chkVal("convStart", 16'h0000, {15'h0000, convStart});
    end
  endtask

  initial begin
    rows[0] = {4'h4, 1'b0, ads_pkg::ADS_SRC_PREAMP, 4'b0000, 2'b00, 14'h1F40};
    rows[1] = {4'h5, 1'b0, ads_pkg::ADS_SRC_REF_LS1, 4'b0011, 2'b00, 14'h0FD2};
    rows[2] = {4'h5, 1'b1, ads_pkg::ADS_SRC_REF_LS1, 4'b0001, 2'b00, 14'h102F};
    rows[3] = {4'h6, 1'b0, ads_pkg::ADS_SRC_SHORT_ADC, 4'b1100, 2'b00, 14'h1FF6};
    rows[4] = {4'h6, 1'b1, ads_pkg::ADS_SRC_GND_LS1, 4'b1101, 2'b00, 14'h2011};
    rows[5] = {4'h9, 1'b0, ads_pkg::ADS_SRC_GND_THERMISTOR_REFERENCE, 4'b1100, 2'b01, 14'h2070};
    rows[6] = {4'hC, 1'b0, ads_pkg::ADS_SRC_SHORT_LS, 4'b1101, 2'b00, 14'h1FD4};
    rows[7] = {4'hA, 1'b0, ads_pkg::ADS_SRC_NEG_SUPPLY, 4'b1100, 2'b00, 14'h0000};
    rows[8] = {4'hB, 1'b0, ads_pkg::ADS_SRC_NEG_SUPPLY, 4'b1100, 2'b10, 14'h3FFF};
    repeat (8) @(posedge clk);
    @(negedge clk);
    chkVal("seqBusy", 16'h0000, {15'h0000, seqBusy});
    chkVal("faultStatusTwo", 16'h0000, {14'h0000, faultStatusTwo});
    chkVal("diagSlotOneResult", 16'h0000, diagSlotOneResult);
    @(posedge clk) rst <= 1'b0;
    // table: each code, codes 5 and 6 once per style, alternating slots
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      diagSlotOneSelect <= (i % 2 == 0) ? rows[i].code : 4'h0;
      diagSlotTwoSelect <= (i % 2 == 1) ? rows[i].code : 4'h0;
      conversionSequenceStyle <= rows[i].style;
      pulseScan();
      doConv(rows[i].res, 1'b0, i % 3, 1'b0);
      waitIdle();
      if (rows[i].code != 4'hB) chkSrc(rows[i].src, capRoute.src);
      if (rows[i].bipCare) chkVal("bipolar", 16'h0001, {15'h0000, capRoute.bipolar});
      if (rows[i].chopCare) begin
        chkVal("chop", {15'h0000, rows[i].chop}, {15'h0000, capRoute.chop});
      end
      chkVal("posSupply", {15'h0000, rows[i].pos}, {15'h0000, capRoute.posSupply});
      if (rows[i].thermistor_reference) chkVal("useThrmRef", 16'h0001, {15'h0000, capRoute.useThrmRef});
      if (rows[i].code == 4'h4) chkVal("thresholdDac", 16'h03FF, {4'h0, capDac});
      if (i % 2 == 0) chkVal("diagSlotOneResult", {rows[i].res, 2'b00}, diagSlotOneResult);
      else chkVal("diagSlotTwoResult", {rows[i].res, 2'b00}, diagSlotTwoResult);
      chkSrc(ads_pkg::ADS_SRC_CELL, route.src);
      chkVal("idle bipolar", 16'h0000, {15'h0000, route.bipolar});
    end
    // both slots, accuracy check and stuck pair, repeat scan-end while busy
    @(posedge clk);
    diagSlotOneSelect <= 4'h4;
    diagSlotTwoSelect <= 4'h5;
    scanTypeField <= 3'h1;
    compAccuracyCheckEnable <= 1'b1;
    endScanStuckCheckEnable <= 1'b1;
    pulseScan();
    doConv(14'h1F3F, 1'b0, 0, 1'b0);
    chkSrc(ads_pkg::ADS_SRC_PREAMP, capRoute.src);
    doConv(14'h0FD2, 1'b0, 1, 1'b1);
    chkSrc(ads_pkg::ADS_SRC_REF_LS1, capRoute.src);
    doConv(14'h0000, 1'b1, 0, 1'b0);
    chkVal("high ls2RefSelect", 16'h0001, {15'h0000, capLs2});
    doConv(14'h0000, 1'b1, 2, 1'b0);
    chkVal("low thresholdDac", 16'h03FF, {4'h0, capDac});
    doConv(14'h0005, 1'b0, 0, 1'b0);
    chkVal("zero posSupply", 16'h0000, {15'h0000, capRoute.posSupply});
    doConv(14'h3FFA, 1'b0, 1, 1'b0);
    chkVal("full posSupply", 16'h0001, {15'h0000, capRoute.posSupply});
    waitIdle();
    noConv();
    chkVal("faultStatusTwo", 16'h0002, {14'h0000, faultStatusTwo});
    chkVal("diagSlotOneResult", 16'h7CFC, diagSlotOneResult);
    chkVal("diagSlotTwoResult", 16'h3F48, diagSlotTwoResult);
    chkVal("stuckZeroResult", 16'h0005, {2'b00, stuckZeroResult});
    chkVal("stuckFullResult", 16'h3FFA, {2'b00, stuckFullResult});
    @(posedge clk) faultClear <= 1'b1;
    @(posedge clk) faultClear <= 1'b0;
    @(negedge clk);
    chkVal("cleared faults", 16'h0000, {14'h0000, faultStatusTwo});
    // margin-shifted limits, second comparator scan type, low limit violated
    @(posedge clk);
    diagSlotOneSelect <= 4'h0;
    diagSlotTwoSelect <= 4'h0;
    endScanStuckCheckEnable <= 1'b0;
    scanTypeField <= 3'h2;
    // path error in limit codes is a sixteenth of the distance from 8195
    // slot one holds 1F3F here: -12.25 codes, so truncation equals rounding
    corr = (int'(diagSlotOneResult[15:2]) - 8195) / 16;
    accuracyHighLimit <= 12'(12'h0411 + corr);
    accuracyLowLimit <= 12'(12'h03ED + corr);
    pulseScan();
    doConv(14'h0000, 1'b0, 0, 1'b0);
    chkVal("high thresholdDac", 16'h0405, {4'h0, capDac});
    doConv(14'h0000, 1'b0, 0, 1'b0);
    chkVal("low thresholdDac", 16'h03E1, {4'h0, capDac});
    waitIdle();
    chkVal("faultStatusTwo", 16'h0001, {14'h0000, faultStatusTwo});
    // other scan types, and comparator scan with the check disabled
    for (int t = 0; t < 9; t++) begin
      if (t == 1 || t == 2) continue;
      @(posedge clk);
      scanTypeField <= (t == 8) ? 3'h1 : t[2:0];
      compAccuracyCheckEnable <= (t != 8);
      pulseScan();
      noConv();
    end
    chkVal("faultStatusTwo", 16'h0001, {14'h0000, faultStatusTwo});
    // reset in mid-pass with a conversion outstanding, then a clean pass
    @(posedge clk);
    diagSlotOneSelect <= 4'h6;
    pulseScan();
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    @(negedge clk);
    chkVal("reset seqBusy", 16'h0000, {15'h0000, seqBusy});
    chkVal("reset convStart", 16'h0000, {15'h0000, convStart});
    chkVal("reset faultStatusTwo", 16'h0000, {14'h0000, faultStatusTwo});
    chkVal("reset diagSlotOneResult", 16'h0000, diagSlotOneResult);
    pulseScan();
    doConv(14'h2000, 1'b0, 0, 1'b0);
    waitIdle();
    chkSrc(ads_pkg::ADS_SRC_SHORT_ADC, capRoute.src);
    chkVal("bipolar", 16'h0001, {15'h0000, capRoute.bipolar});
    chkVal("diagSlotOneResult", 16'h8000, diagSlotOneResult);
    stopTest();
  end
endmodule
